//--- design/acr_pkg.sv
// constants and types shared by the converter start and read control
package acr_pkg;

   // clock and documented intervals
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned PWRUP_PULSE_NS = 1500;
   localparam int unsigned CONV_TIME_NS = 4500;

   // interval lengths in clock cycles, least times rounded up
   localparam int unsigned PWRUP_PULSE_CYC = (PWRUP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // widths
   localparam int unsigned DATA_W = 8;
   localparam int unsigned CNT_W = 12;

   // reset and counter values
   localparam logic [DATA_W-1:0] RESULT_RST = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
   localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;

   // converter core states
   typedef enum logic [1:0] {
      ACR_ST_DOWN,
      ACR_ST_READY,
      ACR_ST_CONV
   } acr_state_t;

endpackage

//--- design/acr_pulse_if.sv
// link between the start control and the power-up pulse timer
`timescale 1ns/1ns
`default_nettype none

interface acr_pulse_if;
   logic fire;
   logic active;

   // control side triggers, timer side answers with the pulse level
   modport ctrl (output fire, input active);
   modport timer (input fire, output active);
endinterface // acr_pulse_if

`default_nettype wire

//--- design/acr_pwrup_timer.sv
// power-up pulse timer: one fixed-length high pulse per trigger
`timescale 1ns/1ns
`default_nettype none

module acr_pwrup_timer
   import acr_pkg::*;
#(
   parameter int unsigned PULSE_CYC = PWRUP_PULSE_CYC
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // pulse link
   acr_pulse_if.timer pif
);

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic active;
   } acr_tmr_t;

   acr_tmr_t q;
   acr_tmr_t d;

   assign pif.active = q.active;

   ////////////////////////////////////////////////////////////////////////////
   // next state: a new trigger restarts the full pulse
   always_comb
   begin
      d = q;
      if (pif.fire)
      begin
         d.cnt = CNT_W'(PULSE_CYC);
         d.active = 1'b1;
      end
      else if (q.cnt == CNT_ONE)
      begin
         d.cnt = CNT_ZERO;
         d.active = 1'b0;
      end
      else if (q.cnt != CNT_ZERO)
      begin
         d.cnt = q.cnt - CNT_ONE;
      end
   end

   // state register
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         q <= '{cnt: CNT_ZERO, active: 1'b0};
      else
         q <= d;
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks: pulse width counted by helper logic
   logic [CNT_W-1:0] width_q;

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b || pif.fire)
         width_q <= CNT_ZERO;
      else if (q.active)
         width_q <= width_q + CNT_ONE;
   end

   AST_PULSE_WIDTH: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $fell(q.active) |-> (width_q == CNT_W'(PULSE_CYC)))
      else $error("power-up pulse width wrong");

   AST_PULSE_START: assert property (@(posedge ref_clk) disable iff (!rst_b)
      pif.fire |=> q.active ##1 q.active)
      else $error("power-up pulse not started by trigger");

endmodule // acr_pwrup_timer

`default_nettype wire

//--- design/acr_adc_ctrl.sv
// converter start sequencing, busy framing, result latch and parallel read port
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - each rising start edge makes a 1.5 us internal high pulse
// - gated start is external start OR internal pulse
// - start already low at pulse end: pulse falling edge begins hold and conversion
// - start still high at pulse end: wait for its falling edge
// - in power-down use the later falling edge starts the first conversion
// - busy goes high and stays high through the conversion
// - conversion end returns sampler to track and drops busy
// - result latched into output register at conversion end
// - start high when busy falls: stay powered, high-speed mode
// - start low before busy falls: power down at conversion end
// - from power-down, wake on next start rising edge, pulse covers power-up
// - read port works while the core is powered down
// - data driven only while chip select and read strobe were both low the cycle before
// - read interface is reset when busy rises
// - after power-on start powered down, waiting for a start rising edge
// - results are straight unsigned binary
module acr_adc_ctrl
   import acr_pkg::*;
#(
   parameter int unsigned PULSE_CYC = PWRUP_PULSE_CYC,
   parameter int unsigned CONV_LEN_CYC = CONV_CYC
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // conversion control pin
   input wire logic conversion_start_n,
   // analog core
   input wire logic [DATA_W-1:0] core_result,
   output logic core_powered,
   output logic sampler_hold,
   output logic high_speed_mode,
   // status pin
   output logic busy,
   // parallel read port
   input wire logic cs_n,
   input wire logic rd_n,
   output logic [DATA_W-1:0] data_out,
   output logic data_oe
);

   typedef struct packed {
      acr_state_t st;
      logic start_q;
      logic gated_q;
      logic [CNT_W-1:0] cnt;
      logic busy;
      logic powered;
      logic hs_mode;
      logic [DATA_W-1:0] result;
      logic [DATA_W-1:0] dout;
      logic oe;
   } acr_ctrl_t;

   acr_ctrl_t q;
   acr_ctrl_t d;
   acr_pulse_if pif ();

   logic start_rise;
   logic gated;
   logic gated_fall;

   ////////////////////////////////////////////////////////////////////////////
   // power-up pulse timer
   acr_pwrup_timer #(
      .PULSE_CYC(PULSE_CYC)
   ) u_timer (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .pif(pif.timer)
   );

   // edge detection and gated start
   assign start_rise = conversion_start_n & ~q.start_q;
   assign gated = conversion_start_n | pif.active;
   assign gated_fall = ~gated & q.gated_q;
   assign pif.fire = start_rise;

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb
   begin
      d = q;
      d.start_q = conversion_start_n;
      d.gated_q = gated;
      unique case (q.st)
         ACR_ST_DOWN:
         begin
            // wake on a start rising edge only
            if (start_rise)
            begin
               d.st = ACR_ST_READY;
               d.powered = 1'b1;
            end
         end
         ACR_ST_READY:
         begin
            // the later of the two falling edges launches the conversion
            if (gated_fall)
            begin
               d.st = ACR_ST_CONV;
               d.busy = 1'b1;
               d.cnt = CNT_W'(CONV_LEN_CYC);
            end
         end
         ACR_ST_CONV:
         begin
            if (q.cnt == CNT_ONE)
            begin
               d.cnt = CNT_ZERO;
               d.busy = 1'b0;
               d.result = core_result;
               d.hs_mode = conversion_start_n;
               d.powered = conversion_start_n;
               d.st = conversion_start_n ? ACR_ST_READY : ACR_ST_DOWN;
            end
            else
            begin
               d.cnt = q.cnt - CNT_ONE;
            end
         end
      endcase
      // read port runs in every state, cleared as busy rises
      d.dout = d.result;
      d.oe = ~cs_n & ~rd_n;
      if (d.busy && !q.busy)
         d.oe = 1'b0;
   end

   // state register, power-on state is powered down
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         q <= '{st: ACR_ST_DOWN, start_q: 1'b0, gated_q: 1'b0, cnt: CNT_ZERO, busy: 1'b0,
                powered: 1'b0, hs_mode: 1'b0, result: RESULT_RST, dout: RESULT_RST, oe: 1'b0};
      else
         q <= d;
   end

   // outputs straight from the state register
   assign core_powered = q.powered;
   assign sampler_hold = q.busy; // hold exactly while converting
   assign high_speed_mode = q.hs_mode;
   assign busy = q.busy;
   assign data_out = q.dout;
   assign data_oe = q.oe;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);

   // helper: length of the current busy frame
   logic [CNT_W-1:0] busy_len_q;

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b || !q.busy)
         busy_len_q <= CNT_ZERO;
      else
         busy_len_q <= busy_len_q + CNT_ONE;
   end

   AST_LAUNCH: assert property ((q.st == ACR_ST_READY) && gated_fall |=> busy ##1 busy)
      else $error("conversion not launched on gated start fall");

   AST_LATER_EDGE: assert property ($rose(busy) |-> !$past(gated) && $past(q.gated_q))
      else $error("busy rose without gated start falling");

   AST_BUSY_LEN: assert property ($fell(busy) |-> busy_len_q == CNT_W'(CONV_LEN_CYC))
      else $error("busy frame length wrong");

   AST_RESULT: assert property ($fell(busy) |-> q.result == $past(core_result))
      else $error("result not latched at conversion end");

   AST_HS_MODE: assert property ($fell(busy) && $past(conversion_start_n) |-> core_powered && high_speed_mode)
      else $error("high-speed mode not kept");

   AST_PDOWN: assert property ($fell(busy) && !$past(conversion_start_n) |-> !core_powered && !high_speed_mode)
      else $error("power-down not entered");

   AST_WAKE: assert property ((q.st == ACR_ST_DOWN) && start_rise |=> core_powered && pif.active)
      else $error("no wake on start rising edge");

   AST_READ_PORT: assert property (data_oe |-> $past(!cs_n && !rd_n) && data_out == q.result)
      else $error("data driven without chip select and read");

   AST_READ_RESET: assert property ($rose(busy) |-> !data_oe)
      else $error("read port not reset as busy rose");

   AST_DOWN_IDLE: assert property (!core_powered && !start_rise |=> !busy)
      else $error("conversion started while powered down");

   ////////////////////////////////////////////////////////////////////////////
   // checks on launch timing, mode keeping and the read port

   // helper: cycles since the core was woken, saturating once a launch is allowed
   logic [CNT_W-1:0] wake_age_q;

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         wake_age_q <= CNT_ZERO;
      else if ((q.st == ACR_ST_DOWN) && start_rise)
         wake_age_q <= CNT_ONE;
      else if ((wake_age_q != CNT_ZERO) && (wake_age_q < CNT_W'(PULSE_CYC + 2)))
         wake_age_q <= wake_age_q + CNT_ONE;
   end

   // no conversion may begin before the power-up pulse has run out
   AST_NO_EARLY_LAUNCH: assert property ($rose(busy) && (wake_age_q != CNT_ZERO) |-> wake_age_q >= CNT_W'(PULSE_CYC + 2))
      else $error("conversion launched before power-up finished");

   // every start rising edge starts or restarts the internal pulse
   AST_RETRIGGER: assert property (start_rise |=> pif.active)
      else $error("start rising edge did not fire the pulse");

   // gated start still high: nothing is launched
   AST_PULSE_GATE: assert property ((q.st == ACR_ST_READY) && (conversion_start_n || pif.active) |=> !busy)
      else $error("conversion launched while gated start high");

   // pulse over but start still high: keep waiting for the pin
   AST_WAIT_HIGH: assert property ((q.st == ACR_ST_READY) && !pif.active && conversion_start_n |=> !busy)
      else $error("conversion launched before start fell");

   // start already low: the pulse falling edge launches
   AST_PULSE_FALL_LAUNCH: assert property ((q.st == ACR_ST_READY) && !conversion_start_n && $fell(pif.active) |=> busy)
      else $error("pulse end did not launch conversion");

   // pulse already over: the pin falling edge launches
   AST_EXT_FALL_LAUNCH: assert property ((q.st == ACR_ST_READY) && !pif.active && $fell(conversion_start_n) |=> busy)
      else $error("start falling edge did not launch conversion");

   // busy stays up until the last conversion cycle
   AST_BUSY_HOLD: assert property (busy && (q.cnt != CNT_ONE) |=> busy)
      else $error("busy dropped early");

   // last conversion cycle returns the sampler to track
   AST_END: assert property ((q.st == ACR_ST_CONV) && (q.cnt == CNT_ONE) |=> !busy && !sampler_hold)
      else $error("conversion did not end");

   // the output register only changes as a conversion ends
   AST_RESULT_STEADY: assert property ($changed(q.result) |-> $fell(busy))
      else $error("result changed outside conversion end");

   // the mode flag only changes as a conversion ends
   AST_MODE_HOLD: assert property (!$fell(busy) |-> $stable(high_speed_mode))
      else $error("mode changed outside conversion end");

   // high-speed mode always keeps the core powered
   AST_HS_STAY: assert property (high_speed_mode |-> core_powered)
      else $error("core unpowered in high-speed mode");

   // a conversion never runs unpowered
   AST_CONV_POWERED: assert property (busy |-> core_powered)
      else $error("conversion without power");

   // released strobes turn the drivers off
   AST_OE_DROP: assert property (cs_n || rd_n |=> !data_oe)
      else $error("data still driven after strobe release");

   // a read outside the busy-rise cycle is served in every state
   AST_OE_RISE: assert property (!cs_n && !rd_n && !((q.st == ACR_ST_READY) && gated_fall) |=> data_oe)
      else $error("read not served");

   // reset leaves the core down and the port quiet
   AST_RESET_STATE: assert property (@(posedge ref_clk) disable iff (1'b0)
      !rst_b |=> !core_powered && !busy && !data_oe && !high_speed_mode)
      else $error("reset state wrong");

   COV_EXT_LAUNCH: cover property ((q.st == ACR_ST_READY) && !pif.active && $fell(conversion_start_n));
   COV_HS_CONV: cover property ($fell(busy) && high_speed_mode);
   COV_PDOWN_CONV: cover property ($fell(busy) && !core_powered);
   COV_READ_IDLE: cover property (data_oe && !core_powered);
   COV_WAKE: cover property ((q.st == ACR_ST_DOWN) && start_rise);

endmodule // acr_adc_ctrl

`default_nettype wire

//--- testbench/acr_host.sv
// host model: drives the start pin and the read strobes
`timescale 1ns/1ns
`default_nettype none

module acr_host
(
   // clock
   input wire logic ref_clk,
   // pins toward the device
   output logic conversion_start_n,
   output logic cs_n,
   output logic rd_n
);
   // start pin low at power-up, strobes idle high
   initial
   begin
      conversion_start_n = 1'b0;
      cs_n = 1'b1;
      rd_n = 1'b1;
   end

   // set the start pin, then hold it n cycles
   task automatic pin(input logic v, input int n);
      @(negedge ref_clk);
      conversion_start_n = v;
      repeat (n) @(negedge ref_clk);
   endtask

   // one read, strobes held low n cycles
   task automatic read(input int n);
      @(negedge ref_clk);
      cs_n = 1'b0;
      rd_n = 1'b0;
      repeat (n) @(negedge ref_clk);
      cs_n = 1'b1;
      rd_n = 1'b1;
   endtask
endmodule // acr_host

`default_nettype wire

//--- testbench/acr_adc_ctrl_bench.sv
// bench: cycle model of the converter control compared every cycle
`timescale 1ns/1ns
`default_nettype none

module acr_adc_ctrl_bench
   import acr_pkg::*;
();
   localparam int PC = 4;
   localparam int CC = 6;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic conversion_start_n, cs_n, rd_n, busy, data_oe;
   logic core_powered, sampler_hold, high_speed_mode;
   logic [DATA_W-1:0] core_result, data_out, res_m;
   logic [15:0] lf = 16'h1022;
   logic pwr_m = 1'b0, hs_m = 1'b0, oe_m = 1'b0, ps = 1'b0, pg = 1'b0, live = 1'b0;
   int pc_m = 0, cc_m = 0, errors = 0, check_count = 0;

   ////////////////////////////////////////////////////////////////
   // clock, random source and design
   initial
   begin
      forever #5 ref_clk = ~ref_clk;
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   always @(negedge ref_clk) lf <= lfsr(lf);
   assign core_result = lf[7:0];

   acr_adc_ctrl #(.PULSE_CYC(PC), .CONV_LEN_CYC(CC)) u_acr_adc_ctrl (.ref_clk(ref_clk), .rst_b(rst_b),
      .conversion_start_n(conversion_start_n), .core_result(core_result), .core_powered(core_powered),
      .sampler_hold(sampler_hold), .high_speed_mode(high_speed_mode), .busy(busy), .cs_n(cs_n),
      .rd_n(rd_n), .data_out(data_out), .data_oe(data_oe));

   acr_host u_acr_host (.ref_clk(ref_clk), .conversion_start_n(conversion_start_n), .cs_n(cs_n), .rd_n(rd_n));

   ////////////////////////////////////////////////////////////////
   // reference model, stepped on the rising edge
   always @(posedge ref_clk)
   begin : model
      logic g;
      g = conversion_start_n | (pc_m > 0);
      live = 1'b1;
      if (!rst_b)
      begin
         pc_m = 0;
         cc_m = 0;
         {pwr_m, hs_m, oe_m, ps, pg} = 5'h00;
         res_m = RESULT_RST;
      end
      else
      begin
         oe_m = !cs_n && !rd_n;
         if (cc_m > 0)
         begin
            if (cc_m == 1)
            begin
               res_m = core_result;
               hs_m = conversion_start_n;
               pwr_m = conversion_start_n;
            end
            cc_m--;
         end
         else if (pwr_m && !g && pg)
         begin
            cc_m = CC;
            oe_m = 1'b0;
         end
         if (pc_m > 0)
            pc_m--;
         if (conversion_start_n && !ps)
         begin
            pc_m = PC;
            pwr_m = 1'b1;
         end
         ps = conversion_start_n;
         pg = g;
      end
   end

   ////////////////////////////////////////////////////////////////
   // compare tasks and per-cycle comparison
   task automatic chk(input logic got, input logic exp);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected flag at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic chkd(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected data at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   always @(negedge ref_clk)
   begin
      if (live)
      begin
         chk(busy, cc_m > 0);
         chk(sampler_hold, cc_m > 0);
         chk(core_powered, pwr_m);
         chk(high_speed_mode, hs_m);
         chk(data_oe, oe_m);
         if (oe_m)
            chkd(data_out, res_m);
      end
   end

   ////////////////////////////////////////////////////////////////
   // bounded wait, closing report
   task automatic end_sim();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic wait_idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 100)
      begin
         @(negedge ref_clk);
         n++;
      end
      if (n == 100)
      begin
         errors++;
         end_sim();
      end
   endtask

   // main sequence
   initial
   begin
      repeat (8) @(negedge ref_clk);
      rst_b = 1'b1;
      u_acr_host.pin(1'b1, 2);
      u_acr_host.pin(1'b0, PC + 2);
      wait_idle();
      u_acr_host.read(3);
      $display("test done: pulse-timed start");
      u_acr_host.pin(1'b1, PC + 5);
      u_acr_host.pin(1'b0, 2);
      wait_idle();
      u_acr_host.read(2);
      $display("test done: edge-timed start");
      u_acr_host.pin(1'b1, PC + 3);
      u_acr_host.pin(1'b0, 3);
      u_acr_host.pin(1'b1, CC + PC + 4);
      u_acr_host.pin(1'b0, PC + 2);
      wait_idle();
      u_acr_host.read(2);
      $display("test done: high speed then power-down");
      u_acr_host.pin(1'b1, 1);
      u_acr_host.pin(1'b0, 0);
      u_acr_host.read(PC + CC + 4);
      wait_idle();
      $display("test done: read across busy rise");
      u_acr_host.pin(1'b1, 1);
      u_acr_host.pin(1'b0, PC + 3);
      u_acr_host.pin(1'b1, 0);
      @(negedge ref_clk);
      rst_b = 1'b0;
      repeat (2) @(negedge ref_clk);
      rst_b = 1'b1;
      u_acr_host.pin(1'b0, PC + 2);
      wait_idle();
      u_acr_host.read(1);
      $display("test done: reset mid-conversion");
      repeat (12)
      begin
         u_acr_host.pin(1'b1, 1 + lf[3:0]);
         u_acr_host.pin(1'b0, PC + 2);
         wait_idle();
         u_acr_host.read(1 + lf[5:4]);
      end
      $display("test done: random spacing");
      end_sim();
   end
endmodule // acr_adc_ctrl_bench

`default_nettype wire
